// ===== include/rtcb_pkg.sv
/*
  Shared constants and types for the circular-buffer and mode-command message handler.
  Assumes a 16-bit RAM word address space and one clock domain.
*/
`default_nettype none
package rtcb_pkg;
  localparam int unsigned AW = 16;
  localparam logic [3:0] CTRL_SIZE_LSB = 4'h4;     // Block size code in control word 7:4
  localparam logic [3:0] CTRL_IRQ_ACC_BIT = 4'hf;  // Interrupt on access, top control bits
  localparam logic [3:0] CTRL_BLK_IRQ_BIT = 4'h0;  // Block done interrupt enable in descriptor
  localparam logic [3:0] INFO_BROADCAST_FLAG_BIT = 4'h9;    // Broadcast flag inside info word
  localparam logic [15:0] IIW_ACCESS = 16'h0001;   // Log info word: access cause
  localparam logic [15:0] MODE_DESC_BASE = 16'h0400;
  localparam logic [15:0] PTR_RST = 16'h0000;
  localparam logic [15:0] INFO_STEP = 16'h0002;
  localparam logic [1:0] PEND_ACCESS = 2'h1;
  localparam logic [1:0] PEND_BLOCK = 2'h2;
  localparam logic [15:0] CA_OFS = 16'h0002;
  localparam logic [15:0] MI_OFS = 16'h0003;
  localparam int unsigned FIFO_DEPTH = 32;
  localparam int unsigned LOG_DEPTH = 64;

  typedef enum logic [7:0] {
    ST_IDLE = 8'h01,
    ST_INFO = 8'h02,
    ST_TTAG = 8'h04,
    ST_DESC_CA = 8'h08,
    ST_DESC_MI = 8'h10,
    ST_LOG_IIW = 8'h20,
    ST_LOG_IAW = 8'h40,
    ST_IRQ_WAIT = 8'h80
  } rtcb_state_e;

  typedef struct packed {
    logic is_mode;
    logic tr;
    logic broadcast_flag;
    logic error;
    logic busy;
    logic sa_illegal;
    logic [4:0] mode_code;
    logic [4:0] word_count;
    logic [15:0] ctrl;
    logic [15:0] buffer_start_pointer;
    logic [15:0] current_data_pointer;
    logic [15:0] msg_info_pointer;
    logic [15:0] desc_addr;
    logic [15:0] info_word;
    logic [15:0] time_tag;
  } rtcb_msg_s;

  typedef struct packed {
    logic recognized;
    logic respond;
    logic message_error_status;
    logic dyn_bus_accept;
    logic send_data;
    logic [15:0] data_addr;
  } rtcb_resp_s;

  typedef struct packed {
    logic [15:0] addr;
    logic [15:0] data;
  } rtcb_ramwr_s;
endpackage
`default_nettype wire

// ===== hdl/rtcb_core.sv
/*
  Message completion handler: circular message-counting buffers, mode command decode,
  interrupt log and pending interrupt bits, with a FIFO in the RAM write path.
  Assumes descriptor words arrive with each message and RAM accepts writes by valid/ready.
*/
// Overview of operation
// - Received data word addresses start at the current data pointer.
// - After the words, write info and time tag, then update pointers.
// - Before block end, info pointer and data pointer move to next slots.
// - On final message, both pointers return to base, low info bits cleared.
// - Block done raises pending bit and interrupt when both enables set.
// - Transmit data word addresses start at the current data pointer.
// - Transmit finishes with info, time tag and pointer update as receive.
// - Broadcast segregation ignored; broadcast data shares the same buffer.
// - Info word carries broadcast flag for every circular-buffer message; mode commands write no info word.
// - Broadcast transmit writes info and time tag, leaves pointers alone.
// - Undefined-mode option touches only the 22 undefined codes.
// - With option clear, undefined codes are valid; table decides legality.
// - Illegal mode command sets message error, status only, no data.
// - With option set, undefined codes get no response and no status change.
// - Illegalization table is all zero after reset.
// - Legal transmit codes 16-31 send clear status plus one data word.
// - Dynamic bus control acceptance status bit is never set.
// - Top control bits select interrupts; no broadcast transmit codes 16-31.
// - Access interrupt sets pending bit and drives interrupt output.
// - Log info and address words are written before interrupt output.
// - Logged address is mode descriptor address from code and direction.
// - Full count when info pointer plus one has all N low bits set.
// - Non-final good message advances info pointer by two.
// - Error, busy or illegal: info words written, pointers kept.
`default_nettype none
module rtcb_fifo #(
  parameter int unsigned WIDTH = 32,
  parameter int unsigned DEPTH = 32
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int unsigned PW = $clog2(DEPTH);
  typedef struct packed {
    logic [PW-1:0] wr;
    logic [PW-1:0] rd;
    logic [PW:0] cnt;
  } rtcb_fptr_s;
  rtcb_fptr_s q, d;
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic push;
  logic pop;

  assign in_ready_o = (q.cnt != DEPTH[PW:0]);
  assign out_valid_o = (q.cnt != '0);
  assign out_data_o = mem_q[q.rd];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  always_comb begin
    d = q;
    if (push) begin
      d.wr = (q.wr == PW'(DEPTH - 1)) ? '0 : q.wr + 1'b1;
    end
    if (pop) begin
      d.rd = (q.rd == PW'(DEPTH - 1)) ? '0 : q.rd + 1'b1;
    end
    d.cnt = q.cnt + {{PW{1'b0}}, push} - {{PW{1'b0}}, pop};
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // Storage needs no reset; empty flag guards every read
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_q[q.wr] <= in_data_i;
    end
  end
endmodule

module rtcb_core
  import rtcb_pkg::*;
#(
  parameter int unsigned FIFO_W = 32,
  parameter int unsigned FIFO_D = rtcb_pkg::FIFO_DEPTH
) (
  input wire logic MCLK_I,
  input wire logic RST_N_I,
  input wire logic MSG_VALID_I,
  output logic MSG_READY_O,
  input wire rtcb_pkg::rtcb_msg_s MSG_I,
  input wire logic UNDEF_MODE_INVALID_I,
  input wire logic [1:0] IRQ_EN_I,
  input wire logic [1:0] PEND_CLR_I,
  output logic [1:0] PEND_O,
  output logic INT_N_O,
  input wire logic ILL_WR_I,
  input wire logic [5:0] ILL_IDX_I,
  input wire logic ILL_BIT_I,
  input wire logic [4:0] WORD_IDX_I,
  output logic [15:0] WORD_ADDR_O,
  output rtcb_pkg::rtcb_resp_s RESP_O,
  output logic RESP_VALID_O,
  output logic [15:0] CUR_PTR_O,
  output logic [15:0] INFO_PTR_O,
  output logic RAM_WR_VALID_O,
  input wire logic RAM_WR_READY_I,
  output rtcb_pkg::rtcb_ramwr_s RAM_WR_O
);
  import rtcb_pkg::*;

  typedef struct packed {
    rtcb_state_e state;
    rtcb_msg_s msg;
    logic [15:0] cur;
    logic [15:0] info;
    logic block_done;
    logic advance;
    logic [1:0] pend;
    logic [63:0] ill;
    rtcb_resp_s resp;
    logic resp_v;
    logic [15:0] word_addr;
    logic [5:0] log_ptr;
  } rtcb_st_s;

  rtcb_st_s q, d;
  logic push_v;
  logic push_rdy;
  rtcb_ramwr_s push_w;
  logic fifo_empty_n;
  logic [15:0] mask;
  logic [15:0] inc;
  logic full;
  logic [4:0] mc;
  logic undef;
  logic illegal;
  logic [15:0] wc;
  logic [5:0] ill_idx;
  logic ignore;
  logic acc_irq;

  // Low info-pointer bits owned by the block counter; loop avoids a too-wide shift
  always_comb begin
    mask = '0;
    for (int b = 0; b < 16; b++) begin
      mask[b] = (b < int'(q.msg.ctrl[CTRL_SIZE_LSB +: 4]));
    end
  end

  assign inc = q.info + 16'h0001;
  assign full = &(inc | ~mask);
  // A zero word count field means 32 words
  assign wc = (q.msg.word_count == 5'h00) ? 16'h0020 : {11'h000, q.msg.word_count};
  assign mc = MSG_I.mode_code;
  assign ill_idx = {MSG_I.tr, mc};

  // The 22 undefined combinations
  always_comb begin
    undef = 1'b0;
    if (!MSG_I.tr) begin
      case (mc)
        5'h10, 5'h12, 5'h13: undef = 1'b1;
        default: undef = !mc[4];
      endcase
    end else begin
      case (mc)
        5'h11, 5'h14, 5'h15: undef = 1'b1;
        default: undef = 1'b0;
      endcase
    end
  end

  assign illegal = q.ill[ill_idx];
  // Unrecognized commands leave status and interrupts alone
  assign ignore = undef && UNDEF_MODE_INVALID_I;
  // Broadcast transmit 16-31 is not a legal command, so it never interrupts
  assign acc_irq = !ignore && MSG_I.ctrl[CTRL_IRQ_ACC_BIT] && IRQ_EN_I[0]
    && !(MSG_I.broadcast_flag && MSG_I.tr && mc[4]);

  always_comb begin
    d = q;
    d.resp_v = 1'b0;
    push_v = 1'b0;
    push_w = '0;
    d.word_addr = q.cur + {11'h000, WORD_IDX_I};
    d.pend = q.pend & ~PEND_CLR_I;
    if (ILL_WR_I) begin
      d.ill[ILL_IDX_I] = ILL_BIT_I;
    end
    case (q.state)
      ST_IDLE: begin
        if (MSG_VALID_I) begin
          d.msg = MSG_I;
          if (MSG_I.is_mode) begin
            d.resp = '0;
            d.resp.dyn_bus_accept = 1'b0;
            d.resp.data_addr = MSG_I.current_data_pointer;
            if (ignore) begin
              // Not recognized: status stays intact for later status requests
              d.resp.recognized = 1'b0;
            end else begin
              d.resp.recognized = 1'b1;
              d.resp.respond = !MSG_I.broadcast_flag;
              d.resp.message_error_status = illegal;
              d.resp.send_data = !illegal && MSG_I.tr && mc[4] && !MSG_I.broadcast_flag;
            end
            d.resp_v = 1'b1;
            if (acc_irq) begin
              d.state = ST_LOG_IIW;
            end
          end else begin
            // Segregation option deliberately not consulted here
            d.cur = MSG_I.current_data_pointer;
            d.info = MSG_I.msg_info_pointer;
            d.state = ST_INFO;
          end
        end
      end
      ST_INFO: begin
        push_v = 1'b1;
        push_w.addr = q.info;
        push_w.data = q.msg.info_word;
        push_w.data[INFO_BROADCAST_FLAG_BIT] = q.msg.broadcast_flag;
        if (push_rdy) begin
          d.state = ST_TTAG;
        end
      end
      ST_TTAG: begin
        push_v = 1'b1;
        push_w.addr = q.info + 16'h0001;
        push_w.data = q.msg.time_tag;
        d.advance = !(q.msg.error || q.msg.busy || q.msg.sa_illegal
          || (q.msg.broadcast_flag && q.msg.tr));
        if (push_rdy) begin
          d.state = d.advance ? ST_DESC_CA : ST_IDLE;
          // A skipped message neither counts towards the block nor moves a pointer
          d.block_done = full && d.advance;
          if (!d.advance) begin
            d.cur = q.cur;
            d.info = q.info;
          end else if (full) begin
            d.cur = q.msg.buffer_start_pointer;
            d.info = q.info & ~mask;
          end else begin
            d.cur = q.cur + wc;
            d.info = q.info + INFO_STEP;
          end
        end
      end
      ST_DESC_CA: begin
        push_v = 1'b1;
        push_w.addr = q.msg.desc_addr + CA_OFS;
        push_w.data = q.cur;
        if (push_rdy) begin
          d.state = ST_DESC_MI;
        end
      end
      ST_DESC_MI: begin
        push_v = 1'b1;
        push_w.addr = q.msg.desc_addr + MI_OFS;
        push_w.data = q.info;
        if (push_rdy) begin
          d.state = (q.block_done && q.msg.ctrl[CTRL_BLK_IRQ_BIT] && IRQ_EN_I[1])
            ? ST_IRQ_WAIT : ST_IDLE;
        end
      end
      ST_LOG_IIW: begin
        push_v = 1'b1;
        push_w.addr = 16'(LOG_DEPTH) + {10'h000, q.log_ptr};
        push_w.data = IIW_ACCESS;
        if (push_rdy) begin
          d.log_ptr = q.log_ptr + 6'h01;
          d.state = ST_LOG_IAW;
        end
      end
      ST_LOG_IAW: begin
        push_v = 1'b1;
        push_w.addr = 16'(LOG_DEPTH) + {10'h000, q.log_ptr};
        push_w.data = MODE_DESC_BASE + {8'h00, q.msg.tr, q.msg.mode_code, 2'h0};
        if (push_rdy) begin
          d.log_ptr = q.log_ptr + 6'h01;
          d.state = ST_IRQ_WAIT;
        end
      end
      ST_IRQ_WAIT: begin
        // Interrupt only once every queued word has reached RAM
        if (!fifo_empty_n) begin
          d.pend = d.pend | (q.msg.is_mode ? PEND_ACCESS : PEND_BLOCK);
          d.state = ST_IDLE;
        end
      end
      default: begin
        d.state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      q <= '0;
      q.state <= ST_IDLE;
      q.cur <= PTR_RST;
      q.info <= PTR_RST;
      q.ill <= 64'h0;
    end else begin
      q <= d;
    end
  end

  rtcb_fifo #(
    .WIDTH(FIFO_W),
    .DEPTH(FIFO_D)
  ) u_fifo (
    .clk_i(MCLK_I),
    .rst_n_i(RST_N_I),
    .in_valid_i(push_v),
    .in_ready_o(push_rdy),
    .in_data_i(push_w),
    .out_valid_o(fifo_empty_n),
    .out_ready_i(RAM_WR_READY_I),
    .out_data_o(RAM_WR_O)
  );

  assign RAM_WR_VALID_O = fifo_empty_n;
  assign MSG_READY_O = (q.state == ST_IDLE);
  assign PEND_O = q.pend;
  assign INT_N_O = ~|q.pend;
  assign WORD_ADDR_O = q.word_addr;
  assign RESP_O = q.resp;
  assign RESP_VALID_O = q.resp_v;
  assign CUR_PTR_O = q.cur;
  assign INFO_PTR_O = q.info;
endmodule
`default_nettype wire

// ===== verification/rtcb_properties.sv
/*
  Port checker for rtcb_core.
  Assumes one clock and an async active-low reset.
*/
`default_nettype none
module rtcb_properties
  import rtcb_pkg::*;
(
  input wire logic MCLK_I,
  input wire logic RST_N_I,
  input wire logic MSG_VALID_I,
  input wire logic MSG_READY_O,
  input wire rtcb_pkg::rtcb_msg_s MSG_I,
  input wire logic UNDEF_MODE_INVALID_I,
  input wire logic [1:0] IRQ_EN_I,
  input wire logic [1:0] PEND_O,
  input wire logic INT_N_O,
  input wire rtcb_pkg::rtcb_resp_s RESP_O,
  input wire logic RESP_VALID_O,
  input wire logic RAM_WR_VALID_O,
  input wire logic RAM_WR_READY_I,
  input wire rtcb_pkg::rtcb_ramwr_s RAM_WR_O
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge MCLK_I);
  endclocking
  default disable iff (!RST_N_I);
  logic tk;
  logic ud;
  assign tk = MSG_VALID_I && MSG_READY_O;
  assign ud = MSG_I.tr ? MSG_I.mode_code inside {5'h11, 5'h14, 5'h15}
    : MSG_I.mode_code <= 5'h10 || MSG_I.mode_code inside {5'h12, 5'h13};
  a_int_pend: assert property (INT_N_O == !(|PEND_O))
    else $error("int differs from pend");
  a_no_dbca: assert property (RESP_VALID_O |-> !RESP_O.dyn_bus_accept)
    else $error("dbca set");
  a_undef_quiet: assert property (tk && MSG_I.is_mode && ud && UNDEF_MODE_INVALID_I
    |=> RESP_VALID_O && !RESP_O.recognized && !RESP_O.respond) else $error("undef answered");
  a_ill_nodata: assert property (RESP_VALID_O && RESP_O.message_error_status |->
    !RESP_O.send_data) else $error("illegal with data");
  a_ram_hold: assert property (RAM_WR_VALID_O && !RAM_WR_READY_I |=>
    RAM_WR_VALID_O && $stable(RAM_WR_O)) else $error("write dropped");
  a_circ_busy: assert property (tk && !MSG_I.is_mode |=> !MSG_READY_O [*2])
    else $error("circ not busy");
  a_irq_drained: assert property ($rose(|PEND_O) |-> !RAM_WR_VALID_O)
    else $error("irq before log");
  a_blk_en: assert property ($rose(PEND_O[1]) |-> IRQ_EN_I[1])
    else $error("block irq masked");
  a_acc_en: assert property ($rose(PEND_O[0]) |-> IRQ_EN_I[0])
    else $error("access irq masked");
  c_mode: cover property (tk && MSG_I.is_mode);
  c_blk: cover property ($rose(PEND_O[1]));
  c_stall: cover property (RAM_WR_VALID_O && !RAM_WR_READY_I);
endmodule
bind rtcb_core rtcb_properties i_rtcb_properties (.MCLK_I(MCLK_I), .RST_N_I(RST_N_I),
  .MSG_VALID_I(MSG_VALID_I), .MSG_READY_O(MSG_READY_O), .MSG_I(MSG_I),
  .UNDEF_MODE_INVALID_I(UNDEF_MODE_INVALID_I), .IRQ_EN_I(IRQ_EN_I), .PEND_O(PEND_O),
  .INT_N_O(INT_N_O), .RESP_O(RESP_O), .RESP_VALID_O(RESP_VALID_O),
  .RAM_WR_VALID_O(RAM_WR_VALID_O), .RAM_WR_READY_I(RAM_WR_READY_I), .RAM_WR_O(RAM_WR_O));
`default_nettype wire

// ===== verification/rtcb_ram_model.sv
/*
  RAM behind the write port.
  Assumes one clock; mode 0 free, 1 alternate stall, 2 blocked.
*/
`default_nettype none
module rtcb_ram_model
  import rtcb_pkg::*;
(
  input wire logic clk_i,
  input wire logic [1:0] mode_i,
  input wire logic wr_valid_i,
  output logic wr_ready_o,
  input wire rtcb_pkg::rtcb_ramwr_s wr_i,
  output int wr_cnt_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] mem [0:65535];
  initial begin
    wr_ready_o = 1'b1;
    wr_cnt_o = 0;
  end
  always @(posedge clk_i) begin
    if (wr_valid_i && wr_ready_o) begin
      mem[wr_i.addr] <= wr_i.data;
      wr_cnt_o <= wr_cnt_o + 1;
    end
    // Ready moves just after the edge, never on it
    wr_ready_o <= #1 (mode_i == 2'h0) || (mode_i == 2'h1 && !wr_ready_o);
  end
endmodule
`default_nettype wire

// ===== verification/testbench.sv
/*
  Self-checking bench for rtcb_core.
  Assumes package, design, RAM model and checker compiled first.
*/
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import rtcb_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic mv = 1'b0;
  logic umi = 1'b0;
  logic ill_wr = 1'b0;
  logic ill_bit = 1'b0;
  logic [5:0] ill_idx = 6'h00;
  logic [1:0] ien = 2'h3;
  logic [1:0] pclr = 2'h0;
  logic [1:0] stl = 2'h1;
  logic [4:0] widx = 5'h05;
  rtcb_msg_s msg = '0;
  logic rdy, int_n, rv, wv, wr_rdy;
  logic [1:0] pend;
  logic [15:0] waddr, cur, inf;
  rtcb_resp_s resp;
  rtcb_ramwr_s wr;
  int wr_cnt, c0;
  int error_cnt = 0;
  int tests_run = 0;
  int cyc = 0;
  always #10 clk = !clk;
  rtcb_core i_rtcb_core (.MCLK_I(clk), .RST_N_I(rst_n), .MSG_VALID_I(mv), .MSG_READY_O(rdy),
    .MSG_I(msg), .UNDEF_MODE_INVALID_I(umi), .IRQ_EN_I(ien), .PEND_CLR_I(pclr),
    .PEND_O(pend), .INT_N_O(int_n), .ILL_WR_I(ill_wr), .ILL_IDX_I(ill_idx),
    .ILL_BIT_I(ill_bit), .WORD_IDX_I(widx), .WORD_ADDR_O(waddr), .RESP_O(resp),
    .RESP_VALID_O(rv), .CUR_PTR_O(cur), .INFO_PTR_O(inf), .RAM_WR_VALID_O(wv),
    .RAM_WR_READY_I(wr_rdy), .RAM_WR_O(wr));
  rtcb_ram_model i_rtcb_ram_model (.clk_i(clk), .mode_i(stl), .wr_valid_i(wv),
    .wr_ready_o(wr_rdy), .wr_i(wr), .wr_cnt_o(wr_cnt));
  function automatic logic [15:0] rd(input logic [15:0] a);
    return i_rtcb_ram_model.mem[a];
  endfunction
  function automatic logic undef(input logic [5:0] k);
    return k[5] ? k[4:0] inside {5'h11, 5'h14, 5'h15}
      : (k[4:0] <= 5'h10 || k[4:0] inside {5'h12, 5'h13});
  endfunction
  task automatic chk(input string n, input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %s exp %h got %h", n, exp, got);
    end
  endtask
  task automatic print_verdict();
    if (error_cnt == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic tick();
    @(posedge clk);
    #1;
  endtask
  task automatic go();
    int n;
    for (n = 0; rdy !== 1'b1 && n < 300; n++) tick();
    mv = 1'b1;
    tick();
    mv = 1'b0;
  endtask
  task automatic idle();
    int n;
    for (n = 0; !(rdy === 1'b1 && wv === 1'b0) && n < 400; n++) tick();
    tick();
  endtask
  task automatic t_circ();
    msg = '0;
    msg.ctrl = 16'h0021;
    msg.buffer_start_pointer = 16'h0200;
    msg.current_data_pointer = 16'h0200;
    msg.msg_info_pointer = 16'h0100;
    msg.desc_addr = 16'h0500;
    msg.word_count = 5'h04;
    msg.broadcast_flag = 1'b1;
    msg.time_tag = 16'h1234;
    go();
    idle();
    chk("broadcast_flag", rd(16'h0100) & 16'h0200, 16'h0200);
    chk("ttag", rd(16'h0101), 16'h1234);
    chk("ca", rd(16'h0502), 16'h0204);
    chk("mi", rd(16'h0503), 16'h0102);
    chk("cur", cur, 16'h0204);
    chk("inf", inf, 16'h0102);
    chk("waddr", waddr, 16'h0209);
    chk("pend", pend, 2'h0);
    msg.broadcast_flag = 1'b0;
    msg.tr = 1'b1;
    msg.current_data_pointer = 16'h0204;
    msg.msg_info_pointer = 16'h0102;
    go();
    idle();
    chk("bcast0", rd(16'h0102) & 16'h0200, 16'h0000);
    chk("mi end", rd(16'h0503), 16'h0100);
    chk("ca end", rd(16'h0502), 16'h0200);
    chk("pend", pend, 2'h2);
    chk("int", int_n, 1'b0);
    pclr = 2'h3;
    tick();
    pclr = 2'h0;
    tick();
    chk("clr", pend, 2'h0);
  endtask
  task automatic t_err();
    c0 = wr_cnt;
    msg.error = 1'b1;
    go();
    idle();
    chk("err wr", 16'(wr_cnt - c0), 16'h0002);
    chk("err cur", cur, 16'h0204);
    chk("err inf", inf, 16'h0102);
    msg.error = 1'b0;
    msg.broadcast_flag = 1'b1;
    go();
    idle();
    chk("bctx wr", 16'(wr_cnt - c0), 16'h0004);
    chk("bctx inf", inf, 16'h0102);
    msg.tr = 1'b0;
    msg.sa_illegal = 1'b1;
    go();
    idle();
    chk("ill wr", 16'(wr_cnt - c0), 16'h0006);
    msg.sa_illegal = 1'b0;
    msg.broadcast_flag = 1'b0;
    msg.busy = 1'b1;
    go();
    idle();
    chk("busy wr", 16'(wr_cnt - c0), 16'h0008);
    chk("busy cur", cur, 16'h0204);
    msg.busy = 1'b0;
    msg.tr = 1'b1;
    ien = 2'h1;
    go();
    idle();
    chk("masked", pend, 2'h0);
    chk("mi end", rd(16'h0503), 16'h0100);
  endtask
  task automatic t_fill();
    c0 = wr_cnt;
    msg.ctrl = 16'h00a0;
    stl = 2'h2;
    repeat (9) go();
    repeat (20) tick();
    chk("full", rdy, 1'b0);
    stl = 2'h0;
    idle();
    chk("drain", 16'(wr_cnt - c0), 16'h0024);
  endtask
  task automatic t_mode();
    logic r;
    msg = '0;
    msg.is_mode = 1'b1;
    msg.current_data_pointer = 16'h0300;
    for (int i = 0; i < 128; i++) begin
      umi = i[6];
      {msg.tr, msg.mode_code} = i[5:0];
      r = !(umi && undef(i[5:0]));
      go();
      chk("rv", rv, 1'b1);
      chk("rec", resp.recognized, r);
      chk("resp", resp.respond, r);
      chk("me", resp.message_error_status, 1'b0);
      chk("data", resp.send_data, r && i[5] && i[4]);
      if (r && i[5] && i[4]) chk("daddr", resp.data_addr, 16'h0300);
      tick();
    end
    umi = 1'b0;
    ill_idx = 6'h32;
    ill_bit = 1'b1;
    ill_wr = 1'b1;
    tick();
    ill_wr = 1'b0;
    {msg.tr, msg.mode_code} = 6'h32;
    go();
    chk("ill me", resp.message_error_status, 1'b1);
    chk("ill data", resp.send_data, 1'b0);
    {msg.tr, msg.mode_code} = 6'h11;
    msg.broadcast_flag = 1'b1;
    tick();
    go();
    chk("bc resp", resp.respond, 1'b0);
  endtask
  task automatic t_irq();
    msg = '0;
    msg.is_mode = 1'b1;
    {msg.tr, msg.mode_code} = 6'h22;
    msg.ctrl = 16'h8000;
    c0 = wr_cnt;
    go();
    idle();
    chk("iiw", rd(16'h0040), 16'h0001);
    chk("iaw", rd(16'h0041), 16'h0488);
    chk("log wr", 16'(wr_cnt - c0), 16'h0002);
    chk("pend", pend, 2'h1);
    chk("int", int_n, 1'b0);
    pclr = 2'h1;
    tick();
    pclr = 2'h0;
    msg.broadcast_flag = 1'b1;
    msg.mode_code = 5'h12;
    go();
    idle();
    chk("bctx irq", pend, 2'h0);
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      error_cnt++;
      print_verdict();
    end
  end
  initial begin
    repeat (12) @(posedge clk);
    #1;
    rst_n = 1'b1;
    chk("int rst", int_n, 1'b1);
    t_circ();
    t_err();
    t_fill();
    t_mode();
    ien = 2'h3;
    t_irq();
    print_verdict();
  end
endmodule
`default_nettype wire
